// [hw/bsc_defines.vh]
// register offsets, field positions, reset values and timing constants
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH

`define BSC_ADR_WDCFG 16'h8203
`define BSC_ADR_OPTION 16'h8204
`define BSC_ADR_SETUP 16'h8205
`define BSC_ADR_REV 16'h8206
`define BSC_ADR_BOOT 16'h820A
`define BSC_ADR_SENSOR 16'h820B

`define BSC_RST_WDCFG 8'h80
`define BSC_RST_SETUP 8'h07
`define BSC_RST_SENSOR 8'hFF
`define BSC_RST_BOOT 2'h3

`define BSC_BIT_LOCK 7
`define BSC_SEL_HI 3
`define BSC_SEL_LO 0
`define BSC_BIT_READY 7
`define BSC_BIT_RUN 6
`define BSC_BIT_AUX 5
`define BSC_BIT_CLK_LATCH 7
`define BSC_BIT_DAT_LATCH 6
`define BSC_SENSOR_ONES 4'hF

`define BSC_CMD_HW_RESET 8'hA5
`define BSC_CMD_PWR_RESET 8'h5A

`define BSC_CLK_PERIOD_NS 4
`define BSC_TICK_NS 100_000_000
`define BSC_TICK_CYCLES (`BSC_TICK_NS / `BSC_CLK_PERIOD_NS)
`define BSC_TICK_MS 100

`define BSC_T_FAST_MS 100
`define BSC_T_SLOW_MS 1000
`define BSC_T_4S_MS 4000
`define BSC_T_8S_MS 8000
`define BSC_T_16S_MS 16000
`define BSC_T_32S_MS 32000
`define BSC_T_64S_MS 64000
`define BSC_T_128S_MS 128000
`define BSC_T_256S_MS 256000

`endif

// [hw/bsc_watchdog_timer.v]
// watchdog period counter with 100 ms prescaler
`timescale 1ns/100ps
`include "bsc_defines.vh"
module bsc_watchdog_timer #(
  parameter integer TICK_CYCLES = `BSC_TICK_CYCLES
) (
  input wire clk_i,
  input wire rstn_i,
  input wire run_i,
  input wire kick_i,
  input wire [11:0] period_ticks_i,
  output wire expire_o
);
  localparam integer TICK_LAST = TICK_CYCLES - 1;

  reg [24:0] pre_q;
  reg [11:0] ticks_q;
  reg kick_prev_q;
  reg expire_q;
  wire [31:0] pre_ext;
  wire tick;
  wire restart;

  assign pre_ext = {7'h00, pre_q};
  assign tick = (pre_ext == TICK_LAST);
  // any level change of the kick restarts the period
  assign restart = !run_i || (kick_i != kick_prev_q);
  assign expire_o = expire_q;

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pre_q <= 25'h000_0000;
      ticks_q <= 12'h000;
      kick_prev_q <= 1'b0;
      expire_q <= 1'b0;
    end
    else
    begin
      kick_prev_q <= kick_i;
      expire_q <= 1'b0;
      if (restart)
      begin
        pre_q <= 25'h000_0000;
        ticks_q <= 12'h000;
      end
      else if (tick)
      begin
        pre_q <= 25'h000_0000;
        // whole ticks only, then start a new period
        if (ticks_q + 12'h001 >= period_ticks_i)
        begin
          ticks_q <= 12'h000;
          expire_q <= 1'b1;
        end
        else
          ticks_q <= ticks_q + 12'h001;
      end
      else
        pre_q <= pre_q + 25'h000_0001;
    end
  end
endmodule

// [hw/bsc_system_regs.v]
// board system control registers on the byte-wide i/o bus
`timescale 1ns/100ps
`include "bsc_defines.vh"

// Operation
// - watchdog config bit 7 locks run enable; reset value 80h.
// - period code 0 gives 1 s on even switch, 100 ms on odd.
// - period codes 1 to 7 give 4 to 256 seconds, doubling.
// - nonzero period codes ignore the configuration switch.
// - option register always reads a fixed eight-bit code.
// - writing A5h starts hardware reset and clears expired flag.
// - writing 5Ah starts power reset and clears expired flag.
// - setup bit 7 drives ready LED high-active, reads back.
// - setup bit 6 starts watchdog, the lock blocks stopping; reports running.
// - setup bit 5 drives auxiliary LED, reads back.
// - setup bits 2..0 power USB port pairs; bits 4,3 read zero.
// - revision register reads fixed logic revision; writes ignored.
// - boot register shows two strap pins in bits 1..0.
// - sensor bits 7,6 set open-collector latches, read pin levels.
// - sensor bits 5,4 read pins; bits 3..0 read one.
// - any change of the kick level restarts the period.
// - action select picks hardware reset or NMI on expiry.
// - expiry while running fires action, drives expired flag low.
module bsc_system_regs #(
  parameter integer TICK_CYCLES = `BSC_TICK_CYCLES,
  parameter [7:0] OPTION_CODE = 8'h3C, // arbitrary value
  parameter [7:0] REVISION_CODE = 8'h01 // arbitrary value
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire [15:0] IO_ADDR_I,
  input wire IO_WR_I,
  input wire IO_RD_I,
  input wire [7:0] IO_WDATA_I,
  output wire [7:0] IO_RDATA_O,
  input wire WATCHDOG_KICK_I,
  input wire WATCHDOG_ACTION_SELECT_I,
  input wire [3:0] CONFIG_SWITCH_I,
  input wire [1:0] BOOT_STRAP_INPUTS_I,
  input wire SENSOR_CLK_I,
  output wire SENSOR_CLK_O,
  output wire SENSOR_CLK_OE_O,
  input wire SENSOR_DAT_I,
  output wire SENSOR_DAT_O,
  output wire SENSOR_DAT_OE_O,
  output wire LED_READY_O,
  output wire LED_AUX_O,
  output wire [2:0] PORT_PAIR_POWER_O,
  output wire WATCHDOG_EXPIRED_N_O,
  output wire HW_RESET_O,
  output wire PWR_RESET_O,
  output wire NMI_O
);
  localparam integer NSYNC = 8;
  localparam [7:0] SENSOR_RST = `BSC_RST_SENSOR;

  reg [7:0] rdata_q;
  reg lock_q;
  reg [3:0] period_select_q;
  reg [7:0] setup_q;
  reg clock_line_latch_q;
  reg data_line_latch_q;
  reg expired_n_q;
  reg hw_reset_q;
  reg pwr_reset_q;
  reg nmi_q;
  reg [7:0] rdata_d;
  reg [7:0] setup_d;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  reg [NSYNC-1:0] sync3_q;
  reg [NSYNC-1:0] pin_q;

  wire [NSYNC-1:0] pin_raw;
  wire [3:0] config_switch;
  wire [1:0] boot_strap;
  wire clk_pin;
  wire dat_pin;
  wire wr_wdcfg;
  wire wr_option;
  wire wr_setup;
  wire wr_sensor;
  wire expire;
  wire [11:0] period_ticks;

  // address match, shared by the read and write paths
  function hit;
    input [15:0] addr;
    input [15:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // period in whole prescaler ticks for a select code and switch value
  function [11:0] period_of;
    input [3:0] sel;
    input sw_odd;
    integer ms;
    integer t;
    begin
      ms = `BSC_T_256S_MS;
      case (sel)
        4'h0: ms = sw_odd ? `BSC_T_FAST_MS : `BSC_T_SLOW_MS;
        4'h1: ms = `BSC_T_4S_MS;
        4'h2: ms = `BSC_T_8S_MS;
        4'h3: ms = `BSC_T_16S_MS;
        4'h4: ms = `BSC_T_32S_MS;
        4'h5: ms = `BSC_T_64S_MS;
        4'h6: ms = `BSC_T_128S_MS;
        4'h7: ms = `BSC_T_256S_MS;
        default: ms = `BSC_T_256S_MS;
      endcase
      t = ms / `BSC_TICK_MS;
      period_of = t[11:0];
    end
  endfunction

  assign pin_raw = {SENSOR_DAT_I, SENSOR_CLK_I, BOOT_STRAP_INPUTS_I,
                    CONFIG_SWITCH_I};

  // three stages; the filtered value moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1)
    begin : gen_sync
      always @(posedge CLK_I)
      begin
        if (!RSTN_I)
        begin
          sync1_q[g] <= 1'b1;
          sync2_q[g] <= 1'b1;
          sync3_q[g] <= 1'b1;
          pin_q[g] <= 1'b1;
        end
        else
        begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g])
            pin_q[g] <= sync3_q[g];
        end
      end
    end
  endgenerate

  assign config_switch = pin_q[3:0];
  assign boot_strap = pin_q[5:4];
  assign clk_pin = pin_q[6];
  assign dat_pin = pin_q[7];

  assign wr_wdcfg = IO_WR_I && hit(IO_ADDR_I, `BSC_ADR_WDCFG);
  assign wr_option = IO_WR_I && hit(IO_ADDR_I, `BSC_ADR_OPTION);
  assign wr_setup = IO_WR_I && hit(IO_ADDR_I, `BSC_ADR_SETUP);
  assign wr_sensor = IO_WR_I && hit(IO_ADDR_I, `BSC_ADR_SENSOR);

  // only bit 0 of the switch matters, and only for code zero
  assign period_ticks =
    period_of(period_select_q, config_switch[0]);

  // watchdog configuration: sticky lock and period select
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      lock_q <= 1'b1;
      period_select_q <= 4'h0;
    end
    else if (wr_wdcfg)
    begin
      // writing zero never clears the lock
      lock_q <= lock_q | IO_WDATA_I[`BSC_BIT_LOCK];
      period_select_q <= IO_WDATA_I[`BSC_SEL_HI:`BSC_SEL_LO];
    end
  end

  // setup write: the lock holds a running watchdog on
  always @*
  begin
    setup_d = setup_q;
    if (wr_setup)
    begin
      setup_d = IO_WDATA_I;
      setup_d[4] = 1'b0;
      setup_d[3] = 1'b0;
      if (lock_q && setup_q[`BSC_BIT_RUN])
        setup_d[`BSC_BIT_RUN] = 1'b1;
    end
  end

  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
      setup_q <= `BSC_RST_SETUP;
    else
      setup_q <= setup_d;
  end

  assign LED_READY_O = setup_q[`BSC_BIT_READY];
  assign LED_AUX_O = setup_q[`BSC_BIT_AUX];
  assign PORT_PAIR_POWER_O = setup_q[2:0];

  // sensor bus: latch high releases the line, low pulls it down
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      clock_line_latch_q <= SENSOR_RST[`BSC_BIT_CLK_LATCH];
      data_line_latch_q <= SENSOR_RST[`BSC_BIT_DAT_LATCH];
    end
    else if (wr_sensor)
    begin
      clock_line_latch_q <= IO_WDATA_I[`BSC_BIT_CLK_LATCH];
      data_line_latch_q <= IO_WDATA_I[`BSC_BIT_DAT_LATCH];
    end
  end

  assign SENSOR_CLK_O = 1'b0;
  assign SENSOR_CLK_OE_O = !clock_line_latch_q;
  assign SENSOR_DAT_O = 1'b0;
  assign SENSOR_DAT_OE_O = !data_line_latch_q;

  bsc_watchdog_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .run_i(setup_q[`BSC_BIT_RUN]),
    .kick_i(WATCHDOG_KICK_I),
    .period_ticks_i(period_ticks),
    .expire_o(expire)
  );

  // expiry action, reset commands and the expired flag
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      expired_n_q <= 1'b1;
      hw_reset_q <= 1'b0;
      pwr_reset_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      hw_reset_q <= 1'b0;
      pwr_reset_q <= 1'b0;
      nmi_q <= 1'b0;
      if (wr_option && IO_WDATA_I == `BSC_CMD_HW_RESET)
        hw_reset_q <= 1'b1;
      if (wr_option && IO_WDATA_I == `BSC_CMD_PWR_RESET)
        pwr_reset_q <= 1'b1;
      if (expire)
      begin
        // an expiry in the clearing cycle wins and keeps the flag low
        expired_n_q <= 1'b0;
        if (WATCHDOG_ACTION_SELECT_I)
          nmi_q <= 1'b1;
        else
          hw_reset_q <= 1'b1;
      end
      else if (wr_option && (IO_WDATA_I == `BSC_CMD_HW_RESET ||
               IO_WDATA_I == `BSC_CMD_PWR_RESET))
        expired_n_q <= 1'b1;
    end
  end

  assign WATCHDOG_EXPIRED_N_O = expired_n_q;
  assign HW_RESET_O = hw_reset_q;
  assign PWR_RESET_O = pwr_reset_q;
  assign NMI_O = nmi_q;

  // read mux; unmapped addresses read zero
  always @*
  begin
    rdata_d = 8'h00;
    if (hit(IO_ADDR_I, `BSC_ADR_WDCFG))
      rdata_d = {lock_q, 3'h0, period_select_q};
    else if (hit(IO_ADDR_I, `BSC_ADR_OPTION))
      rdata_d = OPTION_CODE;
    else if (hit(IO_ADDR_I, `BSC_ADR_SETUP))
      rdata_d = setup_q;
    else if (hit(IO_ADDR_I, `BSC_ADR_REV))
      rdata_d = REVISION_CODE;
    else if (hit(IO_ADDR_I, `BSC_ADR_BOOT))
      rdata_d = {6'h00, boot_strap};
    else if (hit(IO_ADDR_I, `BSC_ADR_SENSOR))
      rdata_d = {clk_pin, dat_pin, clk_pin, dat_pin,
                 `BSC_SENSOR_ONES};
  end

  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
      rdata_q <= 8'h00;
    else if (IO_RD_I)
      rdata_q <= rdata_d;
  end

  assign IO_RDATA_O = rdata_q;
endmodule

// [tb/bsc_props.sv]
// concurrent checks on the system register ports
`timescale 1ns/100ps
module bsc_props #(
  parameter [7:0] OPTION_CODE = 8'h3C
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire [15:0] IO_ADDR_I,
  input wire IO_WR_I,
  input wire IO_RD_I,
  input wire [7:0] IO_WDATA_I,
  input wire [7:0] IO_RDATA_O,
  input wire WATCHDOG_KICK_I,
  input wire WATCHDOG_ACTION_SELECT_I,
  input wire [3:0] CONFIG_SWITCH_I,
  input wire [1:0] BOOT_STRAP_INPUTS_I,
  input wire SENSOR_CLK_I,
  input wire SENSOR_CLK_O,
  input wire SENSOR_CLK_OE_O,
  input wire SENSOR_DAT_I,
  input wire SENSOR_DAT_O,
  input wire SENSOR_DAT_OE_O,
  input wire LED_READY_O,
  input wire LED_AUX_O,
  input wire [2:0] PORT_PAIR_POWER_O,
  input wire WATCHDOG_EXPIRED_N_O,
  input wire HW_RESET_O,
  input wire PWR_RESET_O,
  input wire NMI_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  wire wr_opt = IO_WR_I && IO_ADDR_I == 16'h8204;
  wire wr_set = IO_WR_I && IO_ADDR_I == 16'h8205;
  wire wr_sen = IO_WR_I && IO_ADDR_I == 16'h820B;
  wire rd_opt = IO_RD_I && IO_ADDR_I == 16'h8204;
  wire rd_set = IO_RD_I && IO_ADDR_I == 16'h8205;
  wire rd_sen = IO_RD_I && IO_ADDR_I == 16'h820B;
  property p_hw_reset;
    wr_opt && IO_WDATA_I == 8'hA5 |=>
      HW_RESET_O && WATCHDOG_EXPIRED_N_O ##1 !HW_RESET_O;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("bad hard reset");
  property p_pwr_reset;
    wr_opt && IO_WDATA_I == 8'h5A |=>
      PWR_RESET_O && WATCHDOG_EXPIRED_N_O ##1 !PWR_RESET_O;
  endproperty
  a_pwr_reset: assert property (p_pwr_reset)
    else $error("bad power reset");
  property p_led_write;
    wr_set |=> LED_READY_O == $past(IO_WDATA_I[7]) &&
      LED_AUX_O == $past(IO_WDATA_I[5]);
  endproperty
  a_led_write: assert property (p_led_write)
    else $error("bad led output");
  property p_usb_write;
    wr_set |=> PORT_PAIR_POWER_O == $past(IO_WDATA_I[2:0]);
  endproperty
  a_usb_write: assert property (p_usb_write)
    else $error("bad port power");
  property p_setup_read;
    rd_set |=> IO_RDATA_O[4:3] == 2'b00 &&
      IO_RDATA_O[7] == $past(LED_READY_O) &&
      IO_RDATA_O[2:0] == $past(PORT_PAIR_POWER_O);
  endproperty
  a_setup_read: assert property (p_setup_read)
    else $error("bad setup read");
  property p_sensor_write;
    wr_sen |=> SENSOR_CLK_OE_O != $past(IO_WDATA_I[7]) &&
      SENSOR_DAT_OE_O != $past(IO_WDATA_I[6]) &&
      !SENSOR_CLK_O && !SENSOR_DAT_O;
  endproperty
  a_sensor_write: assert property (p_sensor_write)
    else $error("bad sensor drive");
  property p_sensor_read;
    rd_sen |=> IO_RDATA_O[3:0] == 4'hF;
  endproperty
  a_sensor_read: assert property (p_sensor_read)
    else $error("bad sensor read");
  property p_option_read;
    rd_opt |=> IO_RDATA_O == OPTION_CODE;
  endproperty
  a_option_read: assert property (p_option_read)
    else $error("bad option code");
  property p_action;
    $fell(WATCHDOG_EXPIRED_N_O) |-> NMI_O != HW_RESET_O &&
      NMI_O == $past(WATCHDOG_ACTION_SELECT_I);
  endproperty
  a_action: assert property (p_action)
    else $error("bad expiry action");
  c_nmi: cover property (NMI_O);
  c_wd_reset: cover property ($fell(WATCHDOG_EXPIRED_N_O) && HW_RESET_O);
  c_pwr: cover property (PWR_RESET_O);
endmodule

// [tb/bsc_sensor_model.sv]
// sensor bus wires with pull-ups and a sensor that can hold data low
`timescale 1ns/100ps
module bsc_sensor_model (
  input wire clk_drv_i,
  input wire clk_oe_i,
  input wire dat_drv_i,
  input wire dat_oe_i,
  input wire hold_dat_i,
  output wire clk_o,
  output wire dat_o
);
  // a released line floats high through its pull-up
  assign clk_o = clk_oe_i ? clk_drv_i : 1'b1;
  assign dat_o = hold_dat_i ? 1'b0 :
                 (dat_oe_i ? dat_drv_i : 1'b1);
endmodule

// [tb/bsc_system_regs_bench.sv]
// self-checking bench for the board system registers
`timescale 1ns/100ps
module bsc_system_regs_bench;
  localparam integer TICK = 5;
  // address, write data, expected read; first five rows only read
  localparam logic [31:0] ROWS [15] = '{
    32'h8203_0080, 32'h8205_0007, 32'h820B_00FF, 32'h820A_0003,
    32'h8204_003C, 32'h8206_5501, 32'h8203_0787, 32'h8203_0080,
    32'h8205_BFA7, 32'h8205_0000, 32'h8205_0707, 32'h820B_3F0F,
    32'h820B_7F5F, 32'h820B_FFFF, 32'h8207_5500};
  reg CLK_I = 1'b0, RSTN_I = 1'b0, IO_WR_I = 1'b0, IO_RD_I = 1'b0;
  reg WATCHDOG_KICK_I = 1'b0, WATCHDOG_ACTION_SELECT_I = 1'b0, hold = 1'b0;
  reg [15:0] IO_ADDR_I = 16'h0000;
  reg [7:0] IO_WDATA_I = 8'h00;
  reg [3:0] CONFIG_SWITCH_I = 4'h1;
  reg [1:0] BOOT_STRAP_INPUTS_I = 2'h3;
  wire [7:0] IO_RDATA_O;
  wire [2:0] PORT_PAIR_POWER_O;
  wire SENSOR_CLK_I, SENSOR_CLK_O, SENSOR_CLK_OE_O, SENSOR_DAT_I;
  wire SENSOR_DAT_O, SENSOR_DAT_OE_O, LED_READY_O, LED_AUX_O;
  wire WATCHDOG_EXPIRED_N_O, HW_RESET_O, PWR_RESET_O, NMI_O;
  integer fails = 0, tests_run = 0, cycles = 0, t, i;
  reg [7:0] q;
  bsc_system_regs #(
    .TICK_CYCLES(TICK)
  ) DUT (
    .CLK_I(CLK_I),
    .RSTN_I(RSTN_I),
    .IO_ADDR_I(IO_ADDR_I),
    .IO_WR_I(IO_WR_I),
    .IO_RD_I(IO_RD_I),
    .IO_WDATA_I(IO_WDATA_I),
    .IO_RDATA_O(IO_RDATA_O),
    .WATCHDOG_KICK_I(WATCHDOG_KICK_I),
    .WATCHDOG_ACTION_SELECT_I(WATCHDOG_ACTION_SELECT_I),
    .CONFIG_SWITCH_I(CONFIG_SWITCH_I),
    .BOOT_STRAP_INPUTS_I(BOOT_STRAP_INPUTS_I),
    .SENSOR_CLK_I(SENSOR_CLK_I),
    .SENSOR_CLK_O(SENSOR_CLK_O),
    .SENSOR_CLK_OE_O(SENSOR_CLK_OE_O),
    .SENSOR_DAT_I(SENSOR_DAT_I),
    .SENSOR_DAT_O(SENSOR_DAT_O),
    .SENSOR_DAT_OE_O(SENSOR_DAT_OE_O),
    .LED_READY_O(LED_READY_O),
    .LED_AUX_O(LED_AUX_O),
    .PORT_PAIR_POWER_O(PORT_PAIR_POWER_O),
    .WATCHDOG_EXPIRED_N_O(WATCHDOG_EXPIRED_N_O),
    .HW_RESET_O(HW_RESET_O),
    .PWR_RESET_O(PWR_RESET_O),
    .NMI_O(NMI_O)
  );
  bsc_sensor_model sensor (.clk_drv_i(SENSOR_CLK_O),
    .clk_oe_i(SENSOR_CLK_OE_O), .dat_drv_i(SENSOR_DAT_O),
    .dat_oe_i(SENSOR_DAT_OE_O), .hold_dat_i(hold),
    .clk_o(SENSOR_CLK_I), .dat_o(SENSOR_DAT_I));
  always #2 CLK_I = ~CLK_I;
  task conclude;
    begin
      if (fails == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge CLK_I)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      fails = fails + 1;
      conclude;
    end
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("ERROR %0t saw %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge CLK_I);
      IO_ADDR_I <= a;
      IO_WDATA_I <= d;
      IO_WR_I <= 1'b1;
      @(posedge CLK_I);
      IO_WR_I <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(posedge CLK_I);
      IO_ADDR_I <= a;
      IO_RD_I <= 1'b1;
      @(posedge CLK_I);
      IO_RD_I <= 1'b0;
      @(posedge CLK_I);
      #1 d = IO_RDATA_O;
    end
  endtask
  // restart the period and time the expiry pulse in clock cycles
  task measure(input [3:0] c, input s, input a, input integer n);
    begin
      wr(16'h8203, {4'h0, c});
      @(posedge CLK_I);
      CONFIG_SWITCH_I <= {3'b000, s};
      WATCHDOG_ACTION_SELECT_I <= a;
      repeat (8) @(posedge CLK_I);
      WATCHDOG_KICK_I <= ~WATCHDOG_KICK_I;
      t = 0;
      // pulses from before the restart land in the first cycles
      while (t < 20000 && (t < 4 || !(NMI_O || HW_RESET_O)))
      begin
        @(posedge CLK_I);
        #1 t = t + 1;
      end
      check(t >= n * TICK && t <= n * TICK + 4, 1);
      check(NMI_O, a);
      check(HW_RESET_O, !a);
      check(WATCHDOG_EXPIRED_N_O, 0);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    for (i = 0; i < 15; i = i + 1)
    begin
      if (i > 4)
        wr(ROWS[i][31:16], ROWS[i][15:8]);
      repeat (6) @(posedge CLK_I);
      rd(ROWS[i][31:16], q);
      check(q, ROWS[i][7:0]);
    end
    hold <= 1'b1;
    repeat (6) @(posedge CLK_I);
    rd(16'h820B, q);
    check(q, 8'hAF);
    hold <= 1'b0;
    rd(16'h8205, q); // keep the other setup bits
    wr(16'h8205, q | 8'h40);
    for (i = 1; i < 8; i = i + 1)
      measure(i, i[0], i[1], 40 << (i - 1));
    wr(16'h8204, 8'h5A);
    #1 check(PWR_RESET_O, 1);
    check(WATCHDOG_EXPIRED_N_O, 1);
    measure(0, 1, 1, 1);
    wr(16'h8205, 8'h07);
    rd(16'h8205, q);
    check(q[6], 1);
    measure(0, 0, 1, 10);
    t = 0;
    for (i = 0; i < 200; i = i + 1)
    begin
      @(posedge CLK_I);
      if (i % 20 == 19)
        WATCHDOG_KICK_I <= ~WATCHDOG_KICK_I;
      #1 t = t + (NMI_O || HW_RESET_O);
    end
    check(t[7:0], 0);
    wr(16'h8203, 8'h07);
    wr(16'h8204, 8'hA5);
    #1 check(HW_RESET_O, 1);
    check(WATCHDOG_EXPIRED_N_O, 1);
    wr(16'h8205, 8'hA0);
    wr(16'h8203, 8'h00);
    repeat (80) @(posedge CLK_I);
    #1 check(WATCHDOG_EXPIRED_N_O, 0);
    check(LED_AUX_O, 1);
    // reset in mid-run restores the defaults and stops the watchdog
    @(posedge CLK_I);
    RSTN_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    #1 check(WATCHDOG_EXPIRED_N_O, 1);
    check(LED_READY_O, 0);
    check(LED_AUX_O, 0);
    rd(16'h8205, q);
    check(q, 8'h07);
    rd(16'h8203, q);
    check(q, 8'h80);
    t = 0;
    repeat (100)
    begin
      @(posedge CLK_I);
      #1 t = t + (NMI_O || HW_RESET_O);
    end
    check(t[7:0], 0);
    conclude;
  end
endmodule

bind bsc_system_regs bsc_props #(
  .OPTION_CODE(OPTION_CODE)
) props (
  .CLK_I(CLK_I),
  .RSTN_I(RSTN_I),
  .IO_ADDR_I(IO_ADDR_I),
  .IO_WR_I(IO_WR_I),
  .IO_RD_I(IO_RD_I),
  .IO_WDATA_I(IO_WDATA_I),
  .IO_RDATA_O(IO_RDATA_O),
  .WATCHDOG_KICK_I(WATCHDOG_KICK_I),
  .WATCHDOG_ACTION_SELECT_I(WATCHDOG_ACTION_SELECT_I),
  .CONFIG_SWITCH_I(CONFIG_SWITCH_I),
  .BOOT_STRAP_INPUTS_I(BOOT_STRAP_INPUTS_I),
  .SENSOR_CLK_I(SENSOR_CLK_I),
  .SENSOR_CLK_O(SENSOR_CLK_O),
  .SENSOR_CLK_OE_O(SENSOR_CLK_OE_O),
  .SENSOR_DAT_I(SENSOR_DAT_I),
  .SENSOR_DAT_O(SENSOR_DAT_O),
  .SENSOR_DAT_OE_O(SENSOR_DAT_OE_O),
  .LED_READY_O(LED_READY_O),
  .LED_AUX_O(LED_AUX_O),
  .PORT_PAIR_POWER_O(PORT_PAIR_POWER_O),
  .WATCHDOG_EXPIRED_N_O(WATCHDOG_EXPIRED_N_O),
  .HW_RESET_O(HW_RESET_O),
  .PWR_RESET_O(PWR_RESET_O),
  .NMI_O(NMI_O)
);
